// ### inc/atocr_defines.svh
// register offsets, field positions, reset values and timing figures
// assumes byte-wide registers behind a 13-bit serial port address
`ifndef ATOCR_DEFINES_SVH
`define ATOCR_DEFINES_SVH
`define ATOCR_ADDR_TEST   13'h000d
`define ATOCR_ADDR_BIST   13'h000e
`define ATOCR_ADDR_OFFS   13'h0010
`define ATOCR_ADDR_OMODE  13'h0014
`define ATOCR_ADDR_DRIVE  13'h0015
`define ATOCR_ADDR_PHASE  13'h0016
`define ATOCR_ADDR_DELAY  13'h0017
`define ATOCR_ADDR_SPAN   13'h0018
`define ATOCR_ADDR_USER1L 13'h0019
`define ATOCR_RST_TEST    8'h00
`define ATOCR_RST_BIST    8'h00
`define ATOCR_RST_OFFS    8'h00
`define ATOCR_RST_OMODE   8'h05
`define ATOCR_RST_DRIVE   8'h01
`define ATOCR_RST_PHASE   8'h00
`define ATOCR_RST_DELAY   8'h00
`define ATOCR_RST_SPAN    8'h00
`define ATOCR_RST_USER1L  8'h00
`define ATOCR_MSK_TEST    8'hbf
`define ATOCR_MSK_BIST    8'h05
`define ATOCR_MSK_OFFS    8'h3f
`define ATOCR_MSK_OMODE   8'h17
`define ATOCR_MSK_DRIVE   8'h0f
`define ATOCR_MSK_PHASE   8'h80
`define ATOCR_MSK_DELAY   8'h9f
`define ATOCR_MSK_SPAN    8'h1f
`define ATOCR_BIT_SINGLE  7
`define ATOCR_BIT_PNLONG  5
`define ATOCR_BIT_PNSHORT 4
`define ATOCR_BIT_BISTEN  0
`define ATOCR_BIT_BISTRST 2
`define ATOCR_BIT_OEB     4
`define ATOCR_BIT_INVERT  2
`define ATOCR_BIT_CLKINV  7
`define ATOCR_BIT_DLYEN   7
`define ATOCR_DLY_FULL_PS 3100
`define ATOCR_DLY_DIV     31
`define ATOCR_DLY_BASE_PS 100
`define ATOCR_SPAN_NOM_MV 1750
`define ATOCR_SPAN_P1_MV  1772
`define ATOCR_SPAN_P15_MV 2087
`define ATOCR_SPAN_M1_MV  1727
`define ATOCR_SPAN_M16_MV 1383
`endif

// ### inc/atocr_pkg.sv
// types shared by the configuration block
// assumes nothing beyond the defines header
package atocr_pkg;
    typedef enum logic [1:0] {
        ATOCR_IDLE  = 2'b00,
        ATOCR_INSTR = 2'b01,
        ATOCR_DATA  = 2'b11
    } atocr_port_state_type;
    typedef enum logic [3:0] {
        ATOCR_TM_OFF  = 4'h0, ATOCR_TM_MID  = 4'h1,
        ATOCR_TM_PFS  = 4'h2, ATOCR_TM_NFS  = 4'h3,
        ATOCR_TM_CHK  = 4'h4, ATOCR_TM_PNL  = 4'h5,
        ATOCR_TM_PNS  = 4'h6, ATOCR_TM_TOG  = 4'h7,
        ATOCR_TM_USER = 4'h8
    } atocr_test_mode_type;
    typedef enum logic [1:0] {
        ATOCR_FMT_OFFS = 2'b00, ATOCR_FMT_TWOS = 2'b01,
        ATOCR_FMT_GRAY = 2'b10
    } atocr_format_type;
endpackage : atocr_pkg

// ### verilog/atocr_clock_map.sv
// output clock delay and full-scale span decoding
// assumes register values held stable by the register bank
`timescale 1ns/1ps
`include "atocr_defines.svh"
module atocr_clock_map (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  delayReg,
    input  wire logic [4:0]  spanReg,
    output logic             dlyEn,
    output logic      [11:0] dlyPs,
    output logic      [11:0] spanMv
);
    logic        dlyEn_reg,  dlyEn_next;
    logic [11:0] dlyPs_reg,  dlyPs_next;
    logic [11:0] spanMv_reg, spanMv_next;
    int          code;
    int          mv;

    always_comb begin
        code = int'(delayReg[4:0]);
        mv   = 0;
        dlyEn_next = delayReg[`ATOCR_BIT_DLYEN];
        // code 0 is 100 ps, each step about 100 ps
        dlyPs_next = 12'((`ATOCR_DLY_FULL_PS * code) / `ATOCR_DLY_DIV
                         + `ATOCR_DLY_BASE_PS);
        if (spanReg == 5'h00) begin
            mv = `ATOCR_SPAN_NOM_MV;
        end else if (!spanReg[4]) begin
            mv = `ATOCR_SPAN_P1_MV + ((int'(spanReg) - 1)
                 * (`ATOCR_SPAN_P15_MV - `ATOCR_SPAN_P1_MV)) / 14;
        end else begin
            mv = `ATOCR_SPAN_M1_MV - ((31 - int'(spanReg))
                 * (`ATOCR_SPAN_M1_MV - `ATOCR_SPAN_M16_MV)) / 15;
        end
        spanMv_next = 12'(mv);
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dlyEn_reg  <= 1'b0;
            dlyPs_reg  <= 12'h064;
            spanMv_reg <= 12'h6d6;
        end else begin
            dlyEn_reg  <= dlyEn_next;
            dlyPs_reg  <= dlyPs_next;
            spanMv_reg <= spanMv_next;
        end
    end

    assign dlyEn  = dlyEn_reg;
    assign dlyPs  = dlyPs_reg;
    assign spanMv = spanMv_reg;

    delay_formula_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        delayReg[7] |=> dlyPs == 12'($past(delayReg[4:0]) * 100 + 100)
                        && dlyEn) else $error("clock delay wrong");
    delay_low_codes_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        (delayReg[4:0] == 5'h00) ##1 (delayReg[4:0] == 5'h01)
        |=> $past(dlyPs) == 12'd100 && dlyPs == 12'd200)
        else $error("delay code 0 or 1 wrong");
    span_wide_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (spanReg == 5'h0f |=> spanMv == 12'd2087) and
        (spanReg == 5'h01 |=> spanMv == 12'd1772))
        else $error("wide span wrong");
    span_narrow_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (spanReg == 5'h00 |=> spanMv == 12'd1750) and
        (spanReg == 5'h1f |=> spanMv == 12'd1727) and
        (spanReg == 5'h10 |=> spanMv == 12'd1383))
        else $error("nominal or narrow span wrong");
endmodule : atocr_clock_map

// ### verilog/atocr_pattern_gen.sv
// test pattern generator and output data formatting
// assumes converter words arrive in offset binary every clock
`timescale 1ns/1ps
`include "atocr_defines.svh"
module atocr_pattern_gen (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic [13:0] convData,
    input  wire logic [7:0]  testReg,
    input  wire logic        testRestart,
    input  wire logic [7:0]  userLow,
    input  wire logic [5:0]  offsTrim,
    input  wire logic [7:0]  outMode,
    output logic      [13:0] dataOut,
    output logic             dataEn
);
    logic [13:0] data_reg,  data_next;
    logic        en_reg,    en_next;
    logic [22:0] pnl_reg,   pnl_next;
    logic [8:0]  pns_reg,   pns_next;
    logic        tog_reg,   tog_next;
    logic        shot_reg,  shot_next;
    logic [14:0] trimmed;
    logic [13:0] word;
    logic [13:0] fmt;
    atocr_pkg::atocr_test_mode_type mode;

    always_comb begin
        mode     = atocr_pkg::atocr_test_mode_type'(testReg[3:0]);
        tog_next = ~tog_reg;
        pnl_next = testReg[`ATOCR_BIT_PNLONG] ? 23'h7fffff
                 : {pnl_reg[21:0], pnl_reg[22] ^ pnl_reg[17]};
        pns_next = testReg[`ATOCR_BIT_PNSHORT] ? 9'h1ff
                 : {pns_reg[7:0], pns_reg[8] ^ pns_reg[4]};
        shot_next = 1'b0;
        trimmed = 15'({1'b0, convData}) + 15'({{9{offsTrim[5]}}, offsTrim});
        if (offsTrim[5] && trimmed[14]) begin
            word = 14'h0000;
        end else if (!offsTrim[5] && trimmed[14]) begin
            word = 14'h3fff;
        end else begin
            word = trimmed[13:0];
        end
        unique case (mode)
            atocr_pkg::ATOCR_TM_OFF:  ;
            atocr_pkg::ATOCR_TM_MID:  word = 14'h2000;
            atocr_pkg::ATOCR_TM_PFS:  word = 14'h3fff;
            atocr_pkg::ATOCR_TM_NFS:  word = 14'h0000;
            atocr_pkg::ATOCR_TM_CHK:  word = tog_reg ? 14'h2aaa : 14'h1555;
            atocr_pkg::ATOCR_TM_PNL:  word = pnl_reg[13:0];
            atocr_pkg::ATOCR_TM_PNS:  word = {pns_reg, pns_reg[8:4]};
            atocr_pkg::ATOCR_TM_TOG:  word = tog_reg ? 14'h3fff : 14'h0000;
            atocr_pkg::ATOCR_TM_USER: begin
                // single shot sends once then zeros, else repeats
                word = (shot_reg && !testRestart) ? 14'h0000
                     : {6'h00, userLow};
                shot_next = testReg[`ATOCR_BIT_SINGLE];
            end
            default:                  word = 14'h0000;
        endcase
        unique case (outMode[1:0])
            atocr_pkg::ATOCR_FMT_TWOS: fmt = {~word[13], word[12:0]};
            atocr_pkg::ATOCR_FMT_GRAY: fmt = word ^ {1'b0, word[13:1]};
            default:                   fmt = word;
        endcase
        data_next = outMode[`ATOCR_BIT_INVERT] ? fmt : ~fmt;
        en_next   = ~outMode[`ATOCR_BIT_OEB];
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            data_reg <= 14'h0000;
            en_reg   <= 1'b0;
            pnl_reg  <= 23'h7fffff;
            pns_reg  <= 9'h1ff;
            tog_reg  <= 1'b0;
            shot_reg <= 1'b0;
        end else begin
            data_reg <= data_next;
            en_reg   <= en_next;
            pnl_reg  <= pnl_next;
            pns_reg  <= pns_next;
            tog_reg  <= tog_next;
            shot_reg <= shot_next;
        end
    end

    assign dataOut = data_reg;
    assign dataEn  = en_reg;

    single_shot_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (testReg[3:0] == 4'h8 && testReg[7] && !testRestart) ##1
        (testReg[3:0] == 4'h8 && !testRestart && outMode == 8'h04)
        |=> dataOut == 14'h0000) else $error("single shot repeats");
    invert_data_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (testReg[3:0] == 4'h2 && outMode[2:0] == 3'b000)
        |=> dataOut == 14'h0000) else $error("data not inverted");
    test_on_pins_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (testReg[3:0] == 4'h1 && outMode[2:0] == 3'b100)
        |=> dataOut == 14'h2000) else $error("test word missing");
    conv_return_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (testReg[3:0] == 4'h0 && outMode[2:0] == 3'b100 && offsTrim == 6'h00)
        |=> dataOut == $past(convData))
        else $error("no conversion data");
endmodule : atocr_pattern_gen

// ### verilog/atocr_regs.sv
// test, output and clock configuration registers on a three-wire port
// assumes port pins already synchronous to sys_clk, host idles clock low
`timescale 1ns/1ps
`include "atocr_defines.svh"
module atocr_regs (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        spiClk,
    input  wire logic        spiCsB,
    input  wire logic        sdioIn,
    output logic             sdioOut,
    output logic             sdioOe,
    input  wire logic [13:0] convData,
    output logic      [13:0] dataOut,
    output logic             dataEn,
    output logic             outClkInvert,
    output logic             outClkDelayEn,
    output logic      [11:0] outClkDelayPs,
    output logic      [11:0] spanMv,
    output logic      [3:0]  driveAdjust,
    output logic             bistEnable,
    output logic             bistRestart
);

    atocr_pkg::atocr_port_state_type state_reg, state_next;
    logic        sclkPrev_reg, sclkPrev_next;
    logic [3:0]  bitCnt_reg,   bitCnt_next;
    logic [15:0] inShift_reg,  inShift_next;
    logic        isRead_reg,   isRead_next;
    logic [12:0] addr_reg,     addr_next;
    logic [7:0]  rdShift_reg,  rdShift_next;
    logic [2:0]  rdCnt_reg,    rdCnt_next;
    logic        sdo_reg,      sdo_next;
    logic        sdoOe_reg,    sdoOe_next;

    logic        sclkRise;
    logic        sclkFall;
    logic        wrEn;
    logic [12:0] wrAddr;
    logic [7:0]  wrData;

    logic [7:0]  test_reg,   test_next;
    logic [7:0]  bist_reg,   bist_next;
    logic [7:0]  offs_reg,   offs_next;
    logic [7:0]  omode_reg,  omode_next;
    logic [7:0]  drive_reg,  drive_next;
    logic [7:0]  phase_reg,  phase_next;
    logic [7:0]  delay_reg,  delay_next;
    logic [7:0]  span_reg,   span_next;
    logic [7:0]  user_reg,   user_next;
    logic        restart_reg, restart_next;

    function automatic logic [7:0] readMux(input logic [12:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            `ATOCR_ADDR_TEST:   v = test_reg;
            `ATOCR_ADDR_BIST:   v = bist_reg;
            `ATOCR_ADDR_OFFS:   v = offs_reg;
            `ATOCR_ADDR_OMODE:  v = omode_reg;
            `ATOCR_ADDR_DRIVE:  v = drive_reg;
            `ATOCR_ADDR_PHASE:  v = phase_reg;
            `ATOCR_ADDR_DELAY:  v = delay_reg;
            `ATOCR_ADDR_SPAN:   v = span_reg;
            `ATOCR_ADDR_USER1L: v = user_reg;
            default:            v = 8'h00;
        endcase
        return v;
    endfunction : readMux

    // serial port: 16-bit instruction, then bytes until select rises
    always_comb begin
        sclkPrev_next = spiClk;
        sclkRise      = spiClk & ~sclkPrev_reg;
        sclkFall      = ~spiClk & sclkPrev_reg;
        state_next    = state_reg;
        bitCnt_next   = bitCnt_reg;
        inShift_next  = inShift_reg;
        isRead_next   = isRead_reg;
        addr_next     = addr_reg;
        rdShift_next  = rdShift_reg;
        rdCnt_next    = rdCnt_reg;
        sdo_next      = sdo_reg;
        sdoOe_next    = sdoOe_reg;
        wrEn          = 1'b0;
        wrAddr        = addr_reg;
        wrData        = {inShift_reg[6:0], sdioIn};
        unique case (state_reg)
            atocr_pkg::ATOCR_IDLE: begin
                bitCnt_next = 4'h0;
                sdoOe_next  = 1'b0;
                if (!spiCsB) begin
                    state_next = atocr_pkg::ATOCR_INSTR;
                end
            end
            atocr_pkg::ATOCR_INSTR: begin
                if (sclkRise) begin
                    inShift_next = {inShift_reg[14:0], sdioIn};
                    bitCnt_next  = bitCnt_reg + 4'h1;
                    if (bitCnt_reg == 4'hf) begin
                        isRead_next  = inShift_reg[14];
                        addr_next    = {inShift_reg[11:0], sdioIn};
                        rdShift_next = readMux({inShift_reg[11:0], sdioIn});
                        rdCnt_next   = 3'h0;
                        bitCnt_next  = 4'h0;
                        state_next   = atocr_pkg::ATOCR_DATA;
                    end
                end
            end
            atocr_pkg::ATOCR_DATA: begin
                if (isRead_reg && sclkFall) begin
                    sdoOe_next   = 1'b1;
                    sdo_next     = rdShift_reg[7];
                    rdShift_next = {rdShift_reg[6:0], 1'b0};
                    rdCnt_next   = rdCnt_reg + 3'h1;
                    if (rdCnt_reg == 3'h7) begin
                        addr_next    = addr_reg + 13'h0001;
                        rdShift_next = readMux(addr_reg + 13'h0001);
                    end
                end
                if (!isRead_reg && sclkRise) begin
                    inShift_next = {inShift_reg[14:0], sdioIn};
                    bitCnt_next  = bitCnt_reg + 4'h1;
                    if (bitCnt_reg == 4'h7) begin
                        wrEn        = 1'b1;
                        addr_next   = addr_reg + 13'h0001;
                        bitCnt_next = 4'h0;
                    end
                end
            end
            default: begin
                state_next = atocr_pkg::ATOCR_IDLE;
            end
        endcase
        if (spiCsB) begin
            state_next = atocr_pkg::ATOCR_IDLE;
            sdoOe_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg    <= atocr_pkg::ATOCR_IDLE;
            sclkPrev_reg <= 1'b0;
            bitCnt_reg   <= 4'h0;
            inShift_reg  <= 16'h0000;
            isRead_reg   <= 1'b0;
            addr_reg     <= 13'h0000;
            rdShift_reg  <= 8'h00;
            rdCnt_reg    <= 3'h0;
            sdo_reg      <= 1'b0;
            sdoOe_reg    <= 1'b0;
        end else begin
            state_reg    <= state_next;
            sclkPrev_reg <= sclkPrev_next;
            bitCnt_reg   <= bitCnt_next;
            inShift_reg  <= inShift_next;
            isRead_reg   <= isRead_next;
            addr_reg     <= addr_next;
            rdShift_reg  <= rdShift_next;
            rdCnt_reg    <= rdCnt_next;
            sdo_reg      <= sdo_next;
            sdoOe_reg    <= sdoOe_next;
        end
    end

    // register bank; open bits are masked and read as zero
    always_comb begin
        test_next    = test_reg;
        bist_next    = bist_reg;
        offs_next    = offs_reg;
        omode_next   = omode_reg;
        drive_next   = drive_reg;
        phase_next   = phase_reg;
        delay_next   = delay_reg;
        span_next    = span_reg;
        user_next    = user_reg;
        restart_next = 1'b0;
        if (wrEn) begin
            unique case (wrAddr)
                `ATOCR_ADDR_TEST: begin
                    test_next    = wrData & `ATOCR_MSK_TEST;
                    restart_next = 1'b1;
                end
                `ATOCR_ADDR_BIST:   bist_next  = wrData & `ATOCR_MSK_BIST;
                `ATOCR_ADDR_OFFS:   offs_next  = wrData & `ATOCR_MSK_OFFS;
                `ATOCR_ADDR_OMODE:  omode_next = wrData & `ATOCR_MSK_OMODE;
                `ATOCR_ADDR_DRIVE:  drive_next = wrData & `ATOCR_MSK_DRIVE;
                `ATOCR_ADDR_PHASE:  phase_next = wrData & `ATOCR_MSK_PHASE;
                `ATOCR_ADDR_DELAY:  delay_next = wrData & `ATOCR_MSK_DELAY;
                `ATOCR_ADDR_SPAN:   span_next  = wrData & `ATOCR_MSK_SPAN;
                `ATOCR_ADDR_USER1L: user_next  = wrData;
                default:            ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            test_reg    <= `ATOCR_RST_TEST;
            bist_reg    <= `ATOCR_RST_BIST;
            offs_reg    <= `ATOCR_RST_OFFS;
            omode_reg   <= `ATOCR_RST_OMODE;
            drive_reg   <= `ATOCR_RST_DRIVE;
            phase_reg   <= `ATOCR_RST_PHASE;
            delay_reg   <= `ATOCR_RST_DELAY;
            span_reg    <= `ATOCR_RST_SPAN;
            user_reg    <= `ATOCR_RST_USER1L;
            restart_reg <= 1'b0;
        end else begin
            test_reg    <= test_next;
            bist_reg    <= bist_next;
            offs_reg    <= offs_next;
            omode_reg   <= omode_next;
            drive_reg   <= drive_next;
            phase_reg   <= phase_next;
            delay_reg   <= delay_next;
            span_reg    <= span_next;
            user_reg    <= user_next;
            restart_reg <= restart_next;
        end
    end

    atocr_pattern_gen u_pattern (
        .sys_clk     (sys_clk),
        .rst_b       (rst_b),
        .convData    (convData),
        .testReg     (test_reg),
        .testRestart (restart_reg),
        .userLow     (user_reg),
        .offsTrim    (offs_reg[5:0]),
        .outMode     (omode_reg),
        .dataOut     (dataOut),
        .dataEn      (dataEn)
    );

    atocr_clock_map u_clock_map (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .delayReg (delay_reg),
        .spanReg  (span_reg[4:0]),
        .dlyEn    (outClkDelayEn),
        .dlyPs    (outClkDelayPs),
        .spanMv   (spanMv)
    );

    assign sdioOut      = sdo_reg;
    assign sdioOe       = sdoOe_reg;
    assign outClkInvert = phase_reg[`ATOCR_BIT_CLKINV];
    assign driveAdjust  = drive_reg[3:0];
    assign bistEnable   = bist_reg[`ATOCR_BIT_BISTEN];
    assign bistRestart  = bist_reg[`ATOCR_BIT_BISTRST];

    test_write_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        (wrEn && wrAddr == `ATOCR_ADDR_TEST)
        |=> (test_reg == ($past(wrData) & `ATOCR_MSK_TEST) && restart_reg)
        ##1 !restart_reg)
        else $error("test register write lost");

    test_stands_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        !(wrEn && wrAddr == `ATOCR_ADDR_TEST)
        |=> $stable(test_reg))
        else $error("test mode moved");

    omode_stands_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        !(wrEn && wrAddr == `ATOCR_ADDR_OMODE)
        |=> $stable(omode_reg))
        else $error("output mode moved");

    span_stands_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        !(wrEn && wrAddr == `ATOCR_ADDR_SPAN)
        |=> $stable(span_reg))
        else $error("span code moved");

    select_release_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        spiCsB
        |=> !sdioOe
            && state_reg == atocr_pkg::ATOCR_IDLE)
        else $error("port not released");

    read_bit_a: assert property (@(posedge sys_clk)
        disable iff (!rst_b)
        sclkFall && isRead_reg && !spiCsB
        && state_reg == atocr_pkg::ATOCR_DATA
        |=> sdioOe && sdioOut == $past(rdShift_reg[7]))
        else $error("read bit not driven");
endmodule : atocr_regs

// ### testbench/atocr_host_model.sv
// host model driving the three-wire serial control port
// assumes device read data follows falling serial clock edges
`timescale 1ns/1ps
module atocr_host_model (
    input  wire logic sys_clk,
    input  wire logic sdioOut,
    input  wire logic sdioOe,
    output logic      spiClk,
    output logic      spiCsB,
    output logic      sdioIn
);
    logic hostBit;
    logic hostOe;
    logic idleBit;
    int   halfClk = 3;
    initial begin
        spiClk = 1'b0;
        spiCsB = 1'b1;
        hostBit = 1'b0;
        hostOe = 1'b0;
        idleBit = 1'b0;
    end
    // released wire never keeps its last level
    always @(posedge sys_clk) idleBit <= ~idleBit;
    assign sdioIn = sdioOe ? sdioOut : (hostOe ? hostBit : idleBit);
    // one transfer: instruction then one byte, data moves while clock low
    task automatic xfer(input logic rd, input logic [12:0] addr,
                        input logic [7:0] wdata, output logic [7:0] rdata);
        logic [23:0] sh;
        sh = {rd, 2'b00, addr, wdata};
        rdata = 8'h00;
        @(posedge sys_clk);
        spiCsB <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge sys_clk);
            hostOe <= !(rd && i < 8);
            hostBit <= sh[i];
            repeat (halfClk) @(posedge sys_clk);
            spiClk <= 1'b1;
            if (rd && i < 8) rdata[i] = sdioIn;
            repeat (halfClk) @(posedge sys_clk);
            spiClk <= 1'b0;
        end
        @(posedge sys_clk);
        spiCsB <= 1'b1;
        hostOe <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask : xfer
endmodule : atocr_host_model

// ### testbench/atocr_regs_tb.sv
// self-checking bench for the test, output and clock configuration registers
// assumes the host model owns the serial port pins
`timescale 1ns/1ps
`include "atocr_defines.svh"
module atocr_regs_tb;
    logic        sys_clk;
    logic        rst_b;
    logic        spiClk;
    logic        spiCsB;
    logic        sdioIn;
    logic        sdioOut;
    logic        sdioOe;
    logic [13:0] convData;
    logic [13:0] dataOut;
    logic        dataEn;
    logic        outClkInvert;
    logic        outClkDelayEn;
    logic [11:0] outClkDelayPs;
    logic [11:0] spanMv;
    logic [3:0]  driveAdjust;
    logic        bistEnable;
    logic        bistRestart;
    int          failures;
    int          num_checks;
    logic [31:0] seed;
    logic [7:0]  rd;
    logic [7:0]  d;
    logic [4:0]  c;
    logic [12:0] rAddr [9] = '{`ATOCR_ADDR_TEST, `ATOCR_ADDR_BIST,
        `ATOCR_ADDR_OFFS, `ATOCR_ADDR_OMODE, `ATOCR_ADDR_DRIVE,
        `ATOCR_ADDR_PHASE, `ATOCR_ADDR_DELAY, `ATOCR_ADDR_SPAN,
        `ATOCR_ADDR_USER1L};
    logic [7:0]  rRst [9] = '{8'h00, 8'h00, 8'h00, 8'h05, 8'h01, 8'h00,
        8'h00, 8'h00, 8'h00};
    logic [7:0]  rMsk [9] = '{`ATOCR_MSK_TEST, `ATOCR_MSK_BIST,
        `ATOCR_MSK_OFFS, `ATOCR_MSK_OMODE, `ATOCR_MSK_DRIVE,
        `ATOCR_MSK_PHASE, `ATOCR_MSK_DELAY, `ATOCR_MSK_SPAN, 8'hff};
    logic [4:0]  sCode [5] = '{5'h00, 5'h01, 5'h0f, 5'h1f, 5'h10};
    logic [11:0] sExp [5] = '{12'h6d6, 12'h6ec, 12'h827, 12'h6bf, 12'h567};
    logic [13:0] tExp [3] = '{14'h2000, 14'h3fff, 14'h0000};

    atocr_regs u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .spiClk(spiClk),
        .spiCsB(spiCsB), .sdioIn(sdioIn), .sdioOut(sdioOut),
        .sdioOe(sdioOe), .convData(convData), .dataOut(dataOut),
        .dataEn(dataEn), .outClkInvert(outClkInvert),
        .outClkDelayEn(outClkDelayEn), .outClkDelayPs(outClkDelayPs),
        .spanMv(spanMv), .driveAdjust(driveAdjust),
        .bistEnable(bistEnable), .bistRestart(bistRestart));
    atocr_host_model u_host (.sys_clk(sys_clk), .sdioOut(sdioOut),
        .sdioOe(sdioOe), .spiClk(spiClk), .spiCsB(spiCsB), .sdioIn(sdioIn));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs
    function automatic logic [11:0] dly_exp(input logic [4:0] code);
        return 12'(`ATOCR_DLY_FULL_PS * code / `ATOCR_DLY_DIV
            + `ATOCR_DLY_BASE_PS);
    endfunction : dly_exp
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic [12:0] a, input logic [7:0] v);
        logic [7:0] unused;
        u_host.xfer(1'b0, a, v, unused);
    endtask : wr
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (60000) @(posedge sys_clk);
        failures++;
        $display("watchdog expired");
        end_of_test();
    end
    initial begin
        rst_b = 1'b0;
        convData = 14'h0000;
        seed = 32'd91230;
        failures = 0;
        num_checks = 0;
        repeat (4) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge sys_clk);
        check("delayPs", outClkDelayPs, dly_exp(5'h00));
        check("spanMv", spanMv, `ATOCR_SPAN_NOM_MV);
        for (int i = 0; i < 9; i++) begin
            u_host.xfer(1'b1, rAddr[i], 8'h00, rd);
            check("regReset", rd, rRst[i]);
        end
        $display("test reset done");
        for (int i = 0; i < 9; i++) begin
            d = 8'(xs());
            wr(rAddr[i], d);
            u_host.xfer(1'b1, rAddr[i], 8'h00, rd);
            check("regRw", rd, d & rMsk[i]);
        end
        wr(13'h0011, 8'h5a);
        u_host.xfer(1'b1, 13'h0011, 8'h00, rd);
        check("unmapped", rd, 8'h00);
        wr(`ATOCR_ADDR_PHASE, 8'h80);
        wr(`ATOCR_ADDR_DRIVE, 8'h0a);
        wr(`ATOCR_ADDR_BIST, 8'h05);
        wr(`ATOCR_ADDR_OMODE, 8'h10);
        check("cfgOut", {outClkInvert, driveAdjust, bistRestart,
            bistEnable, dataEn}, 8'hd6);
        $display("test readback done");
        for (int i = 0; i < 6; i++) begin
            c = (i < 2) ? 5'(i) : (i < 4) ? 5'(28 + i) : 5'(xs());
            wr(`ATOCR_ADDR_DELAY, {3'b100, c});
            check("dlyEn", outClkDelayEn, 1'b1);
            check("dlyPs", outClkDelayPs, dly_exp(c));
        end
        $display("test delay done");
        u_host.halfClk = 6;
        for (int i = 0; i < 5; i++) begin
            wr(`ATOCR_ADDR_SPAN, {3'b000, sCode[i]});
            check("spanMv", spanMv, sExp[i]);
        end
        u_host.halfClk = 3;
        $display("test span done");
        wr(`ATOCR_ADDR_TEST, 8'h00);
        wr(`ATOCR_ADDR_OFFS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(`ATOCR_ADDR_OMODE, 8'h04);
            convData <= (i == 0) ? 14'h0000 : (i == 1) ? 14'h3fff : 14'(xs());
            repeat (3) @(posedge sys_clk);
            check("dataNorm", dataOut, convData);
            wr(`ATOCR_ADDR_OMODE, 8'h00);
            check("dataInv", dataOut, 14'(~convData));
        end
        wr(`ATOCR_ADDR_OMODE, 8'h05);
        check("twos", dataOut, convData ^ 14'h2000);
        $display("test invert done");
        wr(`ATOCR_ADDR_OMODE, 8'h04);
        for (int i = 0; i < 3; i++) begin
            wr(`ATOCR_ADDR_TEST, 8'(i + 1));
            check("testWord", dataOut, tExp[i]);
            wr(`ATOCR_ADDR_OMODE, 8'h00);
            check("testInv", dataOut, 14'(~tExp[i]));
            wr(`ATOCR_ADDR_OMODE, 8'h04);
        end
        wr(`ATOCR_ADDR_TEST, 8'h00);
        convData <= 14'h1234;
        repeat (3) @(posedge sys_clk);
        check("convBack", dataOut, 14'h1234);
        $display("test modes done");
        d = 8'(xs());
        wr(`ATOCR_ADDR_USER1L, d);
        wr(`ATOCR_ADDR_TEST, 8'h08);
        repeat (3) begin
            repeat (5) @(posedge sys_clk);
            check("userRepeat", dataOut, {6'h00, d});
        end
        wr(`ATOCR_ADDR_TEST, 8'h88);
        repeat (4) @(posedge sys_clk);
        check("userOnce", dataOut, 14'h0000);
        $display("test user pattern done");
        end_of_test();
    end
endmodule : atocr_regs_tb
